// >>> verilog/dds_core.sv
// dds phase accumulator, waveform path, code fifo and apb registers
// How it works
// - 28-bit accumulator spans one full cycle and wraps modulo 2^28.
// - increment comes from exactly one of two frequency words, pin or bit.
// - switching frequency word never reloads or clears the accumulator.
// - selected 12-bit phase offset adds to accumulator upper bits.
// - two phase offsets, step 1/4096 cycle, exactly one used.
// - upper 12 bits of modulated phase address the sine table.
// - sine table enabled or bypassed by the mode bit alone; output-enable has no effect on it.
// - 10-bit codes go to the converter, one per clock while it keeps up.
// - comparator path enabled only when sign-select and output-enable set.
// - reset pin clears accumulator to zero and holds output at midscale, registers untouched.
// - phase offset chosen by pin or bit like frequency.
// - logic pin driven only with output-enable; select picks comparator or MSB.
// - sleep pin powers down converter, same as sleep bit.
`timescale 1ns/1ps

module dds_fifo #(
	parameter int W = 10,
	parameter int D = 8
) (
	// system
	input wire logic clock_in,
	input wire logic nrst_in,
	// fill side
	input wire logic in_valid_in,
	input wire logic [W-1:0] in_data_in,
	output logic in_ready_out,
	// drain side
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} dds_fifo_s;
	dds_fifo_s q, d;
	logic push, pop;

	assign in_ready_out = q.cnt != (AW+1)'(D);
	assign out_valid_out = q.cnt != '0;
	assign out_data_out = q.mem[q.rd];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wr] = in_data_in;
			d.wr = (q.wr == AW'(D-1)) ? '0 : q.wr + 1'b1;
		end
		if (pop) begin
			d.rd = (q.rd == AW'(D-1)) ? '0 : q.rd + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : dds_fifo

module dds_core import dds_pkg::*; (
	// system
	input wire logic clock_in,
	input wire logic nrst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// asynchronous pins
	input wire logic freq_choice_pin_in,
	input wire logic phase_choice_pin_in,
	input wire logic dds_reset_pin_in,
	input wire logic sleep_pin_in,
	input wire logic comparator_input_in,
	// converter code stream
	output logic [CODE_W-1:0] current_output_code_out,
	output logic code_valid_out,
	input wire logic code_ready_in,
	output logic converter_sleep_out,
	output logic comparator_enable_out,
	// logic output pin
	output logic logic_output_out,
	output logic logic_output_oe_out
);
	typedef struct packed {
		logic [SY_W-1:0] s1;
		logic [SY_W-1:0] s2;
		logic [FREQ_W-1:0] freq_a;
		logic [FREQ_W-1:0] freq_b;
		logic [PHASE_W-1:0] ph_a;
		logic [PHASE_W-1:0] ph_b;
		logic [CTRL_W-1:0] ctrl;
		logic [FREQ_W-1:0] acc;
		logic [31:0] prdata;
		logic lout;
	} dds_state_s;
	dds_state_s q, d;

	logic freq_choice_bit, psel, rst_p, sleep, rom_on, step, in_ready;
	logic [FREQ_W-1:0] inc;
	logic [PHASE_W-1:0] offs, rom_addr;
	logic [CODE_W-1:0] sample;
	logic [2:0] wix;

	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFS_FREQ_A: reg_index = IX_FREQ_A;
			OFS_FREQ_B: reg_index = IX_FREQ_B;
			OFS_PHASE_A: reg_index = IX_PHASE_A;
			OFS_PHASE_B: reg_index = IX_PHASE_B;
			OFS_CTRL: reg_index = IX_CTRL;
			OFS_STATUS: reg_index = IX_STATUS;
			default: reg_index = IX_NONE;
		endcase
	endfunction : reg_index

	// parabola instead of a 4096-entry table: smaller, ~6 percent error
	function automatic logic [CODE_W-1:0] wave(input logic [PHASE_W-1:0] p,
			input logic on);
		logic [21:0] h;
		logic [21:0] prod;
		logic [10:0] amp;
		h = 22'(p[PHASE_W-2:0]);
		prod = h * (HALF_SPAN - h);
		amp = 11'(prod >> AMP_SHIFT);
		if (amp > AMP_MAX) begin
			amp = AMP_MAX;
		end
		if (!on) begin
			wave = p[PHASE_W-1] ? ~p[PHASE_W-2:1] : p[PHASE_W-2:1];
		end else if (p[PHASE_W-1]) begin
			wave = CODE_MID - CODE_W'(amp);
		end else begin
			wave = CODE_MID + CODE_W'(amp);
		end
	endfunction : wave

	// only the second stage is read
	assign rst_p = q.s2[SY_RST];
	assign freq_choice_bit = q.ctrl[C_PINSW] ? q.s2[SY_FREQ_CHOICE_BIT] : q.ctrl[C_FREQ_CHOICE_BIT];
	assign psel = q.ctrl[C_PINSW] ? q.s2[SY_PSEL] : q.ctrl[C_PSEL];
	assign sleep = q.s2[SY_SLEEP] || q.ctrl[C_SLEEP];
	assign inc = freq_choice_bit ? q.freq_b : q.freq_a;
	assign offs = psel ? q.ph_b : q.ph_a;
	assign rom_addr = q.acc[FREQ_W-1 -: PHASE_W] + offs;
	assign rom_on = !q.ctrl[C_MODE];
	assign sample = (rst_p || sleep) ? CODE_MID : wave(rom_addr, rom_on);
	// back-pressure from the converter stalls the accumulator
	assign step = in_ready && !rst_p;
	assign wix = reg_index(paddr_in);

	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && (wix == IX_NONE);
	assign prdata_out = q.prdata;
	assign converter_sleep_out = sleep;
	assign comparator_enable_out = q.ctrl[C_SIGN] && q.ctrl[C_OPBIT];
	assign logic_output_oe_out = q.ctrl[C_OPBIT];
	assign logic_output_out = q.lout;

	always_comb begin
		d = q;
		d.s1 = {comparator_input_in, sleep_pin_in, dds_reset_pin_in,
			phase_choice_pin_in, freq_choice_pin_in};
		d.s2 = q.s1;
		if (rst_p) begin
			d.acc = '0;
		end else if (step) begin
			d.acc = q.acc + inc;
		end
		d.lout = q.ctrl[C_OPBIT] &&
			(q.ctrl[C_SIGN] ? q.s2[SY_CMP] : rom_addr[PHASE_W-1]);
		if (psel_in && !penable_in && !pwrite_in) begin
			unique case (wix)
				IX_FREQ_A: d.prdata = 32'(q.freq_a);
				IX_FREQ_B: d.prdata = 32'(q.freq_b);
				IX_PHASE_A: d.prdata = 32'(q.ph_a);
				IX_PHASE_B: d.prdata = 32'(q.ph_b);
				IX_CTRL: d.prdata = 32'(q.ctrl);
				IX_STATUS: d.prdata = 32'(q.acc);
				default: d.prdata = 32'h0000_0000;
			endcase
		end
		if (psel_in && penable_in && pwrite_in) begin
			unique case (wix)
				IX_FREQ_A: d.freq_a = pwdata_in[FREQ_W-1:0];
				IX_FREQ_B: d.freq_b = pwdata_in[FREQ_W-1:0];
				IX_PHASE_A: d.ph_a = pwdata_in[PHASE_W-1:0];
				IX_PHASE_B: d.ph_b = pwdata_in[PHASE_W-1:0];
				IX_CTRL: d.ctrl = pwdata_in[CTRL_W-1:0];
				default: d.ctrl = q.ctrl;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
		end else begin
			q <= d;
		end
	end

	// one code per clock while the converter keeps up
	dds_fifo #(.W(CODE_W), .D(FIFO_DEPTH)) u_fifo (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.in_valid_in(1'b1),
		.in_data_in(sample),
		.in_ready_out(in_ready),
		.out_valid_out(code_valid_out),
		.out_data_out(current_output_code_out),
		.out_ready_in(code_ready_in)
	);

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);

	a_acc_step: assert property (step
		|=> q.acc == $past(q.acc) + $past(inc))
		else $error("accumulator did not add the increment");
	a_freq_pick: assert property (step && !q.ctrl[C_PINSW]
		|=> q.acc == $past(q.acc) + ($past(q.ctrl[C_FREQ_CHOICE_BIT]) ?
		$past(q.freq_b) : $past(q.freq_a)))
		else $error("wrong frequency word");
	a_pin_freq_choice_bit: assert property (step && q.ctrl[C_PINSW]
		|=> q.acc == $past(q.acc) + ($past(q.s2[SY_FREQ_CHOICE_BIT]) ?
		$past(q.freq_b) : $past(q.freq_a)))
		else $error("frequency pin ignored");
	a_switch_cont: assert property ($changed(freq_choice_bit) && step
		&& !$past(rst_p) |=> q.acc == $past(q.acc) + $past(inc))
		else $error("accumulator reloaded on switch");
	a_phase_add: assert property (!q.ctrl[C_PINSW] |-> rom_addr ==
		PHASE_W'(q.acc[FREQ_W-1 -: PHASE_W]
		+ (q.ctrl[C_PSEL] ? q.ph_b : q.ph_a)))
		else $error("phase offset not applied");
	a_pin_psel: assert property (q.ctrl[C_PINSW] |-> rom_addr ==
		PHASE_W'(q.acc[FREQ_W-1 -: PHASE_W]
		+ (q.s2[SY_PSEL] ? q.ph_b : q.ph_a)))
		else $error("phase pin ignored");
	a_rom_bypass: assert property (q.ctrl[C_MODE] && !rst_p && !sleep
		|-> sample[0] == (rom_addr[1] ^ rom_addr[PHASE_W-1]))
		else $error("table not bypassed in mode");
	a_rom_half: assert property (rom_on && !rst_p && !sleep
		|-> (rom_addr[PHASE_W-1] ? sample <= CODE_MID : sample >= CODE_MID))
		else $error("table half does not follow address msb");
	a_reset_clear: assert property (rst_p |=> q.acc == '0)
		else $error("reset did not clear accumulator");
	a_reset_regs: assert property (rst_p && !pwrite_in
		|=> $stable(q.freq_a) && $stable(q.ctrl))
		else $error("reset pin touched a register");
	a_reset_mid: assert property (rst_p |-> sample == CODE_MID)
		else $error("reset output not midscale");
	a_cmp_gate: assert property (comparator_enable_out
		|=> logic_output_out == $past(q.s2[SY_CMP]))
		else $error("comparator not routed when enabled");
	a_logic_msb: assert property (q.ctrl[C_OPBIT] && !q.ctrl[C_SIGN]
		|=> logic_output_out == $past(rom_addr[PHASE_W-1]))
		else $error("logic pin does not show the phase msb");
	a_pin_drive: assert property (!q.ctrl[C_OPBIT] |=> !q.lout)
		else $error("logic pin active while disabled");
	a_sleep_pin: assert property (q.s2[SY_SLEEP] |-> converter_sleep_out)
		else $error("sleep pin ignored");
	a_sleep_bit: assert property (q.ctrl[C_SLEEP]
		|-> converter_sleep_out)
		else $error("sleep bit ignored");
	a_sleep_mid: assert property (sleep |-> sample == CODE_MID)
		else $error("sleeping converter not fed midscale");
	a_stall_hold: assert property (!in_ready && !rst_p |=> $stable(q.acc))
		else $error("accumulator moved while stalled");
	a_zero_step: assert property (step && inc == '0
		|=> $stable(q.acc))
		else $error("accumulator moved on a zero word");
	a_code_hold: assert property (code_valid_out && !code_ready_in
		|=> code_valid_out && $stable(current_output_code_out))
		else $error("code changed before the converter took it");
	a_full_valid: assert property (!in_ready
		|-> code_valid_out)
		else $error("full buffer shows no code");

	c_freq_switch: cover property ($changed(freq_choice_bit) && step);
	c_fifo_full: cover property (!in_ready);
	c_reset_pin: cover property (rst_p ##1 !rst_p);
	c_comparator: cover property (comparator_enable_out && logic_output_oe_out);
	c_sine_out: cover property (rom_on && !sleep && code_valid_out);
endmodule : dds_core

// >>> verilog/dds_pkg.sv
// constants for the phase accumulator datapath
package dds_pkg;
	localparam int FREQ_W = 28;
	localparam int PHASE_W = 12;
	localparam int CODE_W = 10;
	localparam int CTRL_W = 14;
	localparam int ADDR_W = 8;
	localparam int FIFO_DEPTH = 8;
	// apb byte offsets
	localparam logic [ADDR_W-1:0] OFS_FREQ_A = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FREQ_B = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PHASE_A = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PHASE_B = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	// decoded register index
	localparam logic [2:0] IX_FREQ_A = 3'h0;
	localparam logic [2:0] IX_FREQ_B = 3'h1;
	localparam logic [2:0] IX_PHASE_A = 3'h2;
	localparam logic [2:0] IX_PHASE_B = 3'h3;
	localparam logic [2:0] IX_CTRL = 3'h4;
	localparam logic [2:0] IX_STATUS = 3'h5;
	localparam logic [2:0] IX_NONE = 3'h7;
	// control bit positions
	localparam int C_MODE = 1;
	localparam int C_SIGN = 3;
	localparam int C_OPBIT = 5;
	localparam int C_SLEEP = 6;
	localparam int C_PINSW = 9;
	localparam int C_PSEL = 10;
	localparam int C_FREQ_CHOICE_BIT = 11;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
	// synchroniser lanes
	localparam int SY_W = 5;
	localparam int SY_FREQ_CHOICE_BIT = 0;
	localparam int SY_PSEL = 1;
	localparam int SY_RST = 2;
	localparam int SY_SLEEP = 3;
	localparam int SY_CMP = 4;
	// waveform shaping
	localparam logic [CODE_W-1:0] CODE_MID = 10'h200;
	localparam logic [21:0] HALF_SPAN = 22'h00_0800;
	localparam logic [10:0] AMP_MAX = 11'h1FF;
	localparam int AMP_SHIFT = 11;
endpackage : dds_pkg

// >>> tb/dds_conv_model.sv
// converter sink and comparator model for the code stream
`timescale 1ns/1ps
module dds_conv_model import dds_pkg::*; (
	// system
	input wire logic clock_in,
	input wire logic nrst_in,
	// code stream
	input wire logic [CODE_W-1:0] code_in,
	input wire logic valid_in,
	input wire logic stall_in,
	output logic ready_out,
	// comparator on the filtered output
	output logic comparator_out
);
	// takes one code per clock unless told to stall
	assign ready_out = nrst_in & ~stall_in;
	// sign of the last code stands in for a zero-crossing detector
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			comparator_out <= 1'b0;
		end else if (valid_in & ready_out) begin
			comparator_out <= code_in[CODE_W-1];
		end
	end
endmodule : dds_conv_model

// >>> tb/tb_top.sv
// testbench for the phase accumulator datapath
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	num_errors++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top import dds_pkg::*;;
	logic clock_in, nrst_in, psel, penable, pwrite, fpin, ppin, rpin, spin;
	logic stall, pready, pslverr, err, cmp, vld, rdy, slp, cen, lo, loe;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, q, s1;
	logic [CODE_W-1:0] code;
	int num_errors, check_count;
	localparam int PC [3] = '{2, 2 | 1 << C_PSEL, 2 | 1 << C_PINSW};
	localparam int LC [3] = '{32 | 1 << C_PSEL, 40 | 1 << C_PSEL, 8 | 1024};
	localparam int FC [4] = '{0, 1 << C_FREQ_CHOICE_BIT, 1 << C_PINSW, 1 << C_PINSW};
	localparam logic [27:0] FE [4] = '{28'h0FFF_FFFE, 28'h0000_0246,
		28'h0000_0246, 28'h0FFF_FFFE};
	localparam logic [9:0] PE [3] = '{10'h080, 10'h37F, 10'h37F};
	localparam logic [2:0] LE [3] = '{3'h3, 3'h6, 3'h0};
	dds_core dut (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .freq_choice_pin_in(fpin),
		.phase_choice_pin_in(ppin), .dds_reset_pin_in(rpin),
		.sleep_pin_in(spin), .comparator_input_in(cmp),
		.current_output_code_out(code), .code_valid_out(vld),
		.code_ready_in(rdy), .converter_sleep_out(slp),
		.comparator_enable_out(cen), .logic_output_out(lo),
		.logic_output_oe_out(loe));
	dds_conv_model conv (.clock_in(clock_in), .nrst_in(nrst_in),
		.code_in(code), .valid_in(vld), .stall_in(stall), .ready_out(rdy),
		.comparator_out(cmp));
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	// rel low keeps the bus for a back-to-back transfer
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic rel);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		if (n >= 50) begin
			num_errors++;
			stop_test();
		end
		if (rel) begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clock_in);
		end
	endtask : apb
	task acc_diff;
		apb(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0);
		s1 = q;
		apb(1'b0, OFS_STATUS, 32'h0000_0000, 1'b1);
	endtask : acc_diff
	initial begin
		{nrst_in, psel, penable, pwrite, fpin, ppin, rpin, spin, stall} = 0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge clock_in);
		nrst_in <= 1'b1;
		@(posedge clock_in);
		apb(1'b0, OFS_CTRL, 32'h0000_0000, 1'b1);
		`CHK("ctrl", 32'(CTRL_RESET), q)
		apb(1'b0, 8'h18, 32'h0000_0000, 1'b1);
		`CHK("unmapped", 33'h0_0000_0001, {q, err})
		apb(1'b1, OFS_PHASE_A, 32'h0000_0100, 1'b1);
		apb(1'b1, OFS_PHASE_B, 32'h0000_0900, 1'b1);
		// offsets applied to a stopped accumulator, table bypassed
		for (int i = 0; i < 3; i++) begin
			ppin <= (i == 2);
			apb(1'b1, OFS_CTRL, 32'(PC[i]), 1'b1);
			repeat (16) @(posedge clock_in);
			`CHK("tri_code", PE[i], code)
		end
		ppin <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_CTRL, 32'(LC[i]), 1'b1);
			repeat (16) @(posedge clock_in);
			`CHK("pin_out", LE[i], {cen, loe, lo})
		end
		$display("test phase done");
		apb(1'b1, OFS_CTRL, 32'h0000_0000, 1'b1);
		apb(1'b1, OFS_PHASE_A, 32'h0000_0400, 1'b1);
		repeat (16) @(posedge clock_in);
		`CHK("sine_peak", 10'h3FF, code)
		spin <= 1'b1;
		repeat (4) @(posedge clock_in);
		`CHK("sleep_pin", 1'b1, slp)
		spin <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'(1 << C_SLEEP), 1'b1);
		`CHK("sleep_bit", 1'b1, slp)
		apb(1'b1, OFS_FREQ_A, 32'h0FFF_FFFF, 1'b1);
		apb(1'b1, OFS_FREQ_B, 32'h0000_0123, 1'b1);
		for (int i = 0; i < 4; i++) begin
			fpin <= (i == 2);
			apb(1'b1, OFS_CTRL, 32'(FC[i]), 1'b1);
			repeat (4) @(posedge clock_in);
			acc_diff();
			`CHK("acc_step", FE[i], 28'(q - s1))
		end
		$display("test freq done");
		rpin <= 1'b1;
		repeat (16) @(posedge clock_in);
		apb(1'b0, OFS_STATUS, 32'h0000_0000, 1'b1);
		`CHK("acc_clear", 42'h000_0000_0200, {q, code})
		apb(1'b0, OFS_FREQ_A, 32'h0000_0000, 1'b1);
		`CHK("freq_kept", 32'h0FFF_FFFF, q)
		rpin <= 1'b0;
		stall <= 1'b1;
		repeat (30) @(posedge clock_in);
		acc_diff();
		`CHK("stalled", 33'h1_0000_0000, {vld, q - s1})
		stall <= 1'b0;
		repeat (16) @(posedge clock_in);
		$display("test reset and stall done");
		stop_test();
	end
endmodule : tb_top
